// [csl_pkg.sv]
// Purpose: Shared constants of the core status and link register block
// Assumes: 8-bit data path, 20-bit program counter, 16-bit code words
// Notes:   Register port offsets index 8-bit registers
package csl_pkg;

    // ------------------------------------------------------------
    // Register port offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_LINK_EXT  = 4'h0;
    localparam logic [3:0] OFS_LINK_HIGH = 4'h1;
    localparam logic [3:0] OFS_LINK_LOW  = 4'h2;
    localparam logic [3:0] OFS_CONTROL   = 4'h3;
    localparam logic [3:0] OFS_FLAG      = 4'h4;
    localparam logic [3:0] OFS_TBUF_HIGH = 4'h5;
    localparam logic [3:0] OFS_TBUF_LOW  = 4'h6;
    localparam logic [3:0] OFS_STATUS    = 4'h7;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTL_PAGE_SEL = 0;
    localparam int CTL_GIE      = 1;
    localparam int CTL_IDX_BANK = 2;
    localparam int CTL_GPR_LO   = 3;
    localparam int CTL_GPR_HI   = 4;
    localparam int CTL_STK_EXC  = 5;
    localparam int CTL_IRQ0_EN  = 6;
    localparam int CTL_IRQ1_EN  = 7;

    // ------------------------------------------------------------
    // Flag register fields
    // ------------------------------------------------------------
    localparam int FLG_CARRY = 0;
    localparam int FLG_OVF   = 1;
    localparam int FLG_ZERO  = 2;
    localparam int FLG_NEG   = 3;
    localparam int FLG_STACK = 4;
    localparam logic [7:0] FLG_WMASK = 8'h1f;

    // ------------------------------------------------------------
    // Index register slots
    // ------------------------------------------------------------
    localparam logic [1:0] IDX_PAGE = 2'h0;
    localparam logic [1:0] IDX_OFS0 = 2'h1;
    localparam logic [1:0] IDX_OFS1 = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_RESET  = 8'h00;
    localparam logic [7:0] FLG_RESET  = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h7;

endpackage : csl_pkg

// [csl_core_regs.sv]
// Purpose: Control, flag, link, table and banked registers of the core
// Assumes: Program memory answers in the same cycle as prog_rd_q
// Notes:   Hardware updates win over software writes in the same cycle
//
// Chosen here: the plain strobed port and the placing of the registers.
module csl_core_regs #(
    parameter int unsigned ADDR_W = 4
) (
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                resetn,
    // Register port
    input  wire logic [ADDR_W-1:0]   reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [7:0]          reg_rdata_q,
    // Strap pin
    input  wire logic                small_space_n,
    // Sequencer instructions
    input  wire logic [19:0]         pc_in,
    input  wire logic                link_branch_instr,
    input  wire logic                link_return_instr,
    input  wire logic                prog_read_instr,
    input  wire logic                prog_read_inc_instr,
    input  wire logic                irq_return_instr,
    input  wire logic                irq_service,
    output logic                     pc_load_q,
    output logic      [19:0]         pc_load_val_q,
    // Program memory
    output logic      [19:0]         prog_addr_bus_q,
    output logic                     prog_rd_q,
    input  wire logic [15:0]         prog_data,
    output logic      [7:0]          table_buf_high_q,
    output logic      [7:0]          table_buf_low_q,
    // Interrupt and exception requests
    input  wire logic                nmi_req,
    input  wire logic                irq0_req,
    input  wire logic                irq1_req,
    input  wire logic                stack_fault_evt,
    output logic                     nmi_take_q,
    output logic                     irq0_take_q,
    output logic                     irq1_take_q,
    output logic                     stack_exc_q,
    // ALU flag update
    input  wire logic                alu_upd,
    input  wire logic                alu_upd_ovf,
    input  wire logic [7:0]          alu_result,
    input  wire logic                alu_carry_out,
    input  wire logic                alu_carry_in7,
    // General registers
    input  wire logic                gpr_we,
    input  wire logic [1:0]          gpr_wsel,
    input  wire logic [7:0]          gpr_wdata,
    input  wire logic [1:0]          gpr_rsel,
    output logic      [7:0]          gpr_rdata_q,
    // Index registers
    input  wire logic                idx_we,
    input  wire logic [1:0]          idx_wsel,
    input  wire logic [7:0]          idx_wdata,
    output logic      [7:0]          index_page_byte_q,
    output logic      [7:0]          idx_ofs0_q,
    output logic      [7:0]          idx_ofs1_q,
    output logic      [7:0]          direct_page_q,
    // Core state
    output logic      [7:0]          core_control_q,
    output logic      [7:0]          core_flag_q,
    output logic                     full_space_q
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 3 || ADDR_W > 8) begin : g_bad_addr
        $error("ADDR_W must lie between 3 and 8");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0]             sync;
        logic                   full;
        logic [7:0]             ctl;
        logic [7:0]             flg;
        logic [3:0]             lext;
        logic [7:0]             lhigh;
        logic [7:0]             llow;
        logic [7:0]             table_buf_high;
        logic [7:0]             table_buf_low;
        logic                   pend;
        logic                   pend_inc;
        logic [15:0][7:0]       gpr;
        logic [1:0][2:0][7:0]   idx;
        logic [7:0]             rdata;
        logic                   pc_load;
        logic [19:0]            pc_val;
        logic [19:0]            pa;
        logic                   prd;
        logic                   nmi;
        logic                   irq0;
        logic                   irq1;
        logic                   stk;
        logic [7:0]             gpr_rd;
        logic [7:0]             ipage;
        logic [7:0]             iofs0;
        logic [7:0]             iofs1;
        logic [7:0]             dpage;
    } csl_state_t;

    csl_state_t s_q;
    csl_state_t s_d;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [3:0] gpr_slot(
        input logic [7:0] ctl,
        input logic [1:0] sel
    );
        gpr_slot = {ctl[csl_pkg::CTL_GPR_HI:csl_pkg::CTL_GPR_LO], sel};
    endfunction : gpr_slot

    function automatic logic [3:0] upper_nib(
        input logic       full,
        input logic [3:0] nib
    );
        upper_nib = full ? nib : 4'h0;
    endfunction : upper_nib

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic [7:0] addr8;
    logic       ovf;
    logic       msb;

    assign addr8 = 8'(reg_addr);
    assign ovf   = alu_carry_in7 ^ alu_carry_out;
    assign msb   = alu_result[7];

    always_comb begin
        s_d         = s_q;
        s_d.pc_load = 1'b0;
        s_d.prd     = 1'b0;
        s_d.pend    = 1'b0;

        // Strap filter: change taken once two stages agree
        s_d.sync = {s_q.sync[1:0], small_space_n};
        if (s_q.sync[1] == s_q.sync[2]) begin
            s_d.full = s_q.sync[2];
        end

        // Software writes
        if (reg_wr) begin
            case (addr8)
                8'(csl_pkg::OFS_LINK_EXT): s_d.lext = reg_wdata[3:0];
                8'(csl_pkg::OFS_LINK_HIGH): s_d.lhigh = reg_wdata;
                8'(csl_pkg::OFS_LINK_LOW): s_d.llow = reg_wdata;
                8'(csl_pkg::OFS_CONTROL): s_d.ctl = reg_wdata;
                8'(csl_pkg::OFS_FLAG): begin
                    s_d.flg = reg_wdata & csl_pkg::FLG_WMASK;
                end
                default: begin
                end
            endcase
        end

        // Link-and-branch and link-return
        if (link_branch_instr) begin
            s_d.llow  = pc_in[7:0];
            s_d.lhigh = pc_in[15:8];
            if (s_q.full) begin
                s_d.lext = pc_in[19:16];
            end
        end
        if (link_return_instr) begin
            s_d.pc_load = 1'b1;
            s_d.pc_val  = {upper_nib(s_q.full, s_q.lext),
                           s_q.lhigh, s_q.llow};
        end

        // Program memory address and table reads
        s_d.pa = {upper_nib(s_d.full, pc_in[19:16]), pc_in[15:0]};
        if (prog_read_instr || prog_read_inc_instr) begin
            s_d.prd      = 1'b1;
            s_d.pend     = 1'b1;
            s_d.pend_inc = prog_read_inc_instr;
            s_d.pa       = {upper_nib(s_d.full, s_q.lext),
                            s_q.lhigh, s_q.llow};
        end
        if (s_q.pend) begin
            s_d.table_buf_high = prog_data[15:8];
            s_d.table_buf_low = prog_data[7:0];
            if (s_q.pend_inc) begin
                s_d.llow = s_q.llow + 8'h01;
            end
        end

        // Global interrupt enable housekeeping
        if (irq_return_instr) begin
            s_d.ctl[csl_pkg::CTL_GIE] = 1'b1;
        end
        if (irq_service) begin
            s_d.ctl[csl_pkg::CTL_GIE] = 1'b0;
        end

        // Interrupt and exception gating
        s_d.nmi  = nmi_req;
        s_d.irq0 = irq0_req && s_q.ctl[csl_pkg::CTL_GIE]
                   && s_q.ctl[csl_pkg::CTL_IRQ0_EN];
        s_d.irq1 = irq1_req && s_q.ctl[csl_pkg::CTL_GIE]
                   && s_q.ctl[csl_pkg::CTL_IRQ1_EN];
        s_d.stk  = stack_fault_evt
                   && s_q.ctl[csl_pkg::CTL_STK_EXC];

        // ALU flags
        if (alu_upd) begin
            s_d.flg[csl_pkg::FLG_CARRY] = alu_carry_out;
            s_d.flg[csl_pkg::FLG_ZERO]  = (alu_result == 8'h00);
            if (alu_upd_ovf) begin
                s_d.flg[csl_pkg::FLG_OVF] = ovf;
                s_d.flg[csl_pkg::FLG_NEG] = ovf ^ msb;
            end else begin
                s_d.flg[csl_pkg::FLG_NEG] = msb;
            end
        end
        if (stack_fault_evt) begin
            s_d.flg[csl_pkg::FLG_STACK] = 1'b1;
        end

        // General registers, current bank only
        if (gpr_we) begin
            s_d.gpr[gpr_slot(s_q.ctl, gpr_wsel)] = gpr_wdata;
        end
        s_d.gpr_rd = s_d.gpr[gpr_slot(s_d.ctl, gpr_rsel)];

        // Index registers, current bank only
        if (idx_we && idx_wsel != 2'h3) begin
            s_d.idx[s_q.ctl[csl_pkg::CTL_IDX_BANK]][idx_wsel] = idx_wdata;
        end
        s_d.ipage = s_d.idx[s_d.ctl[csl_pkg::CTL_IDX_BANK]][csl_pkg::IDX_PAGE];
        s_d.iofs0 = s_d.idx[s_d.ctl[csl_pkg::CTL_IDX_BANK]][csl_pkg::IDX_OFS0];
        s_d.iofs1 = s_d.idx[s_d.ctl[csl_pkg::CTL_IDX_BANK]][csl_pkg::IDX_OFS1];
        s_d.dpage = s_d.ctl[csl_pkg::CTL_PAGE_SEL] ? s_d.ipage
                                                   : 8'h00;

        // Register read data, valid the cycle after the strobe
        s_d.rdata = 8'h00;
        if (reg_rd) begin
            case (addr8)
                8'(csl_pkg::OFS_LINK_EXT): s_d.rdata = {4'h0, s_q.lext};
                8'(csl_pkg::OFS_LINK_HIGH): s_d.rdata = s_q.lhigh;
                8'(csl_pkg::OFS_LINK_LOW): s_d.rdata = s_q.llow;
                8'(csl_pkg::OFS_CONTROL): s_d.rdata = s_q.ctl;
                8'(csl_pkg::OFS_FLAG): begin
                    s_d.rdata = s_q.flg & csl_pkg::FLG_WMASK;
                end
                8'(csl_pkg::OFS_TBUF_HIGH): s_d.rdata = s_q.table_buf_high;
                8'(csl_pkg::OFS_TBUF_LOW): s_d.rdata = s_q.table_buf_low;
                8'(csl_pkg::OFS_STATUS): s_d.rdata = {7'h00, s_q.full};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_q          <= '0;
            s_q.sync     <= csl_pkg::SYNC_RESET;
            s_q.full     <= 1'b1;
            s_q.ctl      <= csl_pkg::CTL_RESET;
            s_q.flg      <= csl_pkg::FLG_RESET;
            s_q.rdata    <= csl_pkg::DATA_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_q       = s_q.rdata;
    assign pc_load_q         = s_q.pc_load;
    assign pc_load_val_q     = s_q.pc_val;
    assign prog_addr_bus_q   = s_q.pa;
    assign prog_rd_q         = s_q.prd;
    assign table_buf_high_q  = s_q.table_buf_high;
    assign table_buf_low_q   = s_q.table_buf_low;
    assign nmi_take_q        = s_q.nmi;
    assign irq0_take_q       = s_q.irq0;
    assign irq1_take_q       = s_q.irq1;
    assign stack_exc_q       = s_q.stk;
    assign gpr_rdata_q       = s_q.gpr_rd;
    assign index_page_byte_q = s_q.ipage;
    assign idx_ofs0_q        = s_q.iofs0;
    assign idx_ofs1_q        = s_q.iofs1;
    assign direct_page_q     = s_q.dpage;
    assign core_control_q    = s_q.ctl;
    assign core_flag_q       = s_q.flg & csl_pkg::FLG_WMASK;
    assign full_space_q      = s_q.full;

endmodule : csl_core_regs

// [csl_core_regs_assertions.sv]
// Purpose: Concurrent checks on the core status and link register ports
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Attached to the register block by bind
module csl_regs_checker (
    // Observed ports
    input wire logic        clock,
    input wire logic        resetn,
    input wire logic        link_return_instr,
    input wire logic        pc_load_q,
    input wire logic        prog_read_instr,
    input wire logic        prog_rd_q,
    input wire logic [15:0] prog_data,
    input wire logic [7:0]  table_buf_high_q,
    input wire logic [19:0] prog_addr_bus_q,
    input wire logic        full_space_q,
    input wire logic        irq0_req,
    input wire logic        irq0_take_q,
    input wire logic        irq_service,
    input wire logic        irq_return_instr,
    input wire logic [7:0]  core_control_q,
    input wire logic        alu_upd,
    input wire logic        alu_upd_ovf,
    input wire logic [7:0]  alu_result,
    input wire logic        alu_carry_out,
    input wire logic        alu_carry_in7,
    input wire logic [7:0]  core_flag_q,
    input wire logic        stack_fault_evt
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_return_pulse: assert property (link_return_instr |=> pc_load_q)
        else $error("Link return gave no PC load pulse");
    a_read_strobe: assert property (prog_read_instr |=> prog_rd_q)
        else $error("Program read gave no memory strobe");
    a_buf_capture: assert property (prog_rd_q |=> table_buf_high_q == $past(prog_data[15:8]))
        else $error("High table buffer missed the code word");
    a_small_addr: assert property (!full_space_q && $past(!full_space_q) |-> prog_addr_bus_q[19:16] == 4'h0)
        else $error("Upper address bits active in small space");
    a_irq0_gate: assert property (irq0_take_q == $past(irq0_req && core_control_q[1] && core_control_q[6]))
        else $error("Source 0 gating wrong");
    a_service_clear: assert property (irq_service |=> !core_control_q[1])
        else $error("Service entry left global enable set");
    a_return_set: assert property (irq_return_instr && !irq_service |=> core_control_q[1])
        else $error("Interrupt return left global enable clear");
    a_zero_flag: assert property (alu_upd |=> core_flag_q[2] == ($past(alu_result) == 8'h00))
        else $error("Zero flag wrong");
    a_ovf_flag: assert property (alu_upd && alu_upd_ovf |=> core_flag_q[1] == $past(alu_carry_in7 ^ alu_carry_out))
        else $error("Overflow flag wrong");
    a_stack_flag: assert property (stack_fault_evt |=> core_flag_q[4])
        else $error("Stack fault flag not set");
    a_resv_zero: assert property (core_flag_q[7:5] == 3'h0)
        else $error("Reserved flag bits not zero");
endmodule : csl_regs_checker

bind csl_core_regs csl_regs_checker i_csl_regs_checker (
    .clock(clock), .resetn(resetn), .link_return_instr(link_return_instr),
    .pc_load_q(pc_load_q), .prog_read_instr(prog_read_instr), .prog_rd_q(prog_rd_q),
    .prog_data(prog_data), .table_buf_high_q(table_buf_high_q),
    .prog_addr_bus_q(prog_addr_bus_q), .full_space_q(full_space_q), .irq0_req(irq0_req),
    .irq0_take_q(irq0_take_q), .irq_service(irq_service), .irq_return_instr(irq_return_instr),
    .core_control_q(core_control_q), .alu_upd(alu_upd), .alu_upd_ovf(alu_upd_ovf),
    .alu_result(alu_result), .alu_carry_out(alu_carry_out), .alu_carry_in7(alu_carry_in7),
    .core_flag_q(core_flag_q), .stack_fault_evt(stack_fault_evt)
);

// [csl_prog_mem_model.sv]
// Purpose: Program memory answering table reads of the register block
// Assumes: Code word must stand in the cycle of the memory strobe
// Notes:   Outside a read the data lines toggle, never hold the old word
module csl_prog_mem_model (
    // Memory side
    input  wire logic        clock,
    input  wire logic        prog_rd_q,
    input  wire logic [19:0] prog_addr_bus_q,
    output logic      [15:0] prog_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial prog_data = 16'h0000;

    // Word pattern tied to every address bit
    always @(posedge clock) begin
        #1;
        if (prog_rd_q) begin
            prog_data = {prog_addr_bus_q[7:0] ^ 8'h3c,
                         prog_addr_bus_q[15:8] ^ {4'h0, prog_addr_bus_q[19:16]}};
        end else begin
            prog_data = ~prog_data;
        end
    end
endmodule : csl_prog_mem_model

// [testbench.sv]
// Purpose: Self-checking bench of the core status and link registers
// Assumes: Register reads answer one cycle after the read strobe
// Notes:   Random values from a fixed-seed shift register
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, resetn, reg_wr, reg_rd, small_space_n, gpr_we, idx_we;
    logic        alu_upd_ovf, alu_carry_out, alu_carry_in7, pc_load_q, prog_rd_q, full_space_q;
    logic [6:0]  ins;
    logic [3:0]  req, take, reg_addr;
    logic [1:0]  gpr_wsel, gpr_rsel, idx_wsel;
    logic [7:0]  reg_wdata, alu_result, gpr_wdata, idx_wdata, rd, ctl, r, ovf;
    logic [7:0]  reg_rdata_q, table_buf_high_q, table_buf_low_q, gpr_rdata_q, idx_ofs0_q;
    logic [7:0]  index_page_byte_q, idx_ofs1_q, direct_page_q, core_control_q, core_flag_q;
    logic [19:0] pc_in, pc, pc_load_val_q, prog_addr_bus_q;
    logic [15:0] prog_data;
    logic [31:0] lf;
    logic [7:0]  page_m [8]  = '{default: 8'h00};
    logic [7:0]  gm     [16] = '{default: 8'h00};
    int          err_count, cmp_count;

    csl_core_regs i_csl_core_regs (
        .clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .small_space_n(small_space_n), .pc_in(pc_in), .link_branch_instr(ins[0]),
        .link_return_instr(ins[1]), .prog_read_instr(ins[2]), .prog_read_inc_instr(ins[3]),
        .irq_return_instr(ins[4]), .irq_service(ins[5]), .pc_load_q(pc_load_q),
        .pc_load_val_q(pc_load_val_q), .prog_addr_bus_q(prog_addr_bus_q),
        .prog_rd_q(prog_rd_q), .prog_data(prog_data), .table_buf_high_q(table_buf_high_q),
        .table_buf_low_q(table_buf_low_q), .nmi_req(req[0]), .irq0_req(req[1]),
        .irq1_req(req[2]), .stack_fault_evt(req[3]), .nmi_take_q(take[0]),
        .irq0_take_q(take[1]), .irq1_take_q(take[2]), .stack_exc_q(take[3]),
        .alu_upd(ins[6]), .alu_upd_ovf(alu_upd_ovf), .alu_result(alu_result),
        .alu_carry_out(alu_carry_out), .alu_carry_in7(alu_carry_in7), .gpr_we(gpr_we),
        .gpr_wsel(gpr_wsel), .gpr_wdata(gpr_wdata), .gpr_rsel(gpr_rsel),
        .gpr_rdata_q(gpr_rdata_q), .idx_we(idx_we), .idx_wsel(idx_wsel),
        .idx_wdata(idx_wdata), .index_page_byte_q(index_page_byte_q),
        .idx_ofs0_q(idx_ofs0_q), .idx_ofs1_q(idx_ofs1_q), .direct_page_q(direct_page_q),
        .core_control_q(core_control_q), .core_flag_q(core_flag_q),
        .full_space_q(full_space_q)
    );
    csl_prog_mem_model i_csl_prog_mem_model (.clock(clock), .prog_rd_q(prog_rd_q),
        .prog_addr_bus_q(prog_addr_bus_q), .prog_data(prog_data));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function automatic logic [15:0] word(input logic [19:0] a);
        return {a[7:0] ^ 8'h3c, a[15:8] ^ {4'h0, a[19:16]}};
    endfunction : word
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1 rd = reg_rdata_q;
    endtask : reg_read
    task automatic step(input logic [6:0] i, input logic [19:0] p);
        @(posedge clock);
        ins   <= i;
        pc_in <= p;
        @(posedge clock);
        ins   <= 7'h00;
        #1;
    endtask : step
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        finish_test();
    end

    initial begin
        {resetn, reg_wr, reg_rd, gpr_we, idx_we, alu_upd_ovf, alu_carry_out, alu_carry_in7} = '0;
        {ins, req, reg_addr, gpr_wsel, gpr_rsel, idx_wsel, reg_wdata, alu_result} = '0;
        {gpr_wdata, idx_wdata, pc_in} = '0;
        small_space_n = 1'b1;
        lf = 32'hc50d;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            reg_read(i[3:0]);
            check(rd, (i == 7) ? 8'h01 : 8'h00);
        end
        $display("Test reset values done");
        for (int n = 0; n < 8; n++) begin
            lf = lfsr(lf);
            pc = lf[19:0];
            step(7'h01, pc);
            reg_read(4'h0);
            check(rd, {4'h0, pc[19:16]});
            reg_read(4'h1);
            check(rd, pc[15:8]);
            reg_read(4'h2);
            check(rd, pc[7:0]);
            step(7'h02, ~pc);
            check({pc_load_q, pc_load_val_q}, {1'b1, pc});
        end
        $display("Test link and return done");
        for (int v = 0; v < 2; v++) begin
            lf = lfsr(lf);
            pc = {lf[19:8], 8'hff};
            reg_write(4'h0, {4'h0, pc[19:16]});
            reg_write(4'h1, pc[15:8]);
            reg_write(4'h2, pc[7:0]);
            step(v ? 7'h08 : 7'h04, pc_in);
            check({prog_rd_q, prog_addr_bus_q}, {1'b1, pc});
            @(posedge clock);
            #1 check({table_buf_high_q, table_buf_low_q}, word(pc));
            reg_read(4'h2);
            check(rd, v ? 8'h00 : 8'hff);
        end
        $display("Test table reads done");
        @(posedge clock);
        small_space_n <= 1'b0;
        repeat (6) @(posedge clock);
        #1 check(full_space_q, 1'b0);
        reg_write(4'h0, 8'h0a);
        step(7'h04, 20'hf1234);
        check(prog_addr_bus_q[19:16], 4'h0);
        step(7'h01, 20'hf5678);
        reg_read(4'h0);
        check(rd, 8'h0a);
        step(7'h02, 20'h00000);
        check(pc_load_val_q, 20'h05678);
        @(posedge clock);
        small_space_n <= 1'b1;
        repeat (6) @(posedge clock);
        $display("Test small space done");
        for (int n = 0; n < 12; n++) begin
            lf = lfsr(lf);
            ctl = lf[7:0];
            @(posedge clock);
            req <= lf[11:8];
            reg_write(4'h3, ctl);
            {gpr_we, idx_we, idx_wsel} <= {2'h3, lf[15:14]};
            {gpr_wsel, gpr_rsel} <= {2{lf[13:12]}};
            {gpr_wdata, idx_wdata} <= lf[31:16];
            gm[{ctl[4:3], lf[13:12]}] = lf[31:24];
            // Slot 3 of an index bank does not exist, so that write is dropped
            if (lf[15:14] != 2'h3) begin
                page_m[{ctl[2], lf[15:14]}] = lf[23:16];
            end
            @(posedge clock);
            {gpr_we, idx_we} <= 2'h0;
            repeat (2) @(posedge clock);
            #1 check(core_control_q, ctl);
            check(direct_page_q, ctl[0] ? page_m[{ctl[2], 2'h0}] : 8'h00);
            check(index_page_byte_q, page_m[{ctl[2], 2'h0}]);
            check({idx_ofs0_q, idx_ofs1_q},
                  {page_m[{ctl[2], 2'h1}], page_m[{ctl[2], 2'h2}]});
            check(gpr_rdata_q, gm[{ctl[4:3], lf[13:12]}]);
            check(take, {lf[11] & ctl[5], lf[10] & ctl[1] & ctl[7], lf[9] & ctl[1] & ctl[6],
                         lf[8]});
        end
        @(posedge clock);
        req <= 4'h0;
        reg_write(4'h3, 8'h00);
        for (int k = 0; k < 4; k++) begin
            step(k[0] ? (k[1] ? 7'h30 : 7'h20) : 7'h10, pc_in);
            reg_read(4'h3);
            check(rd, {6'h00, ~k[0], 1'b0});
        end
        reg_write(4'h3, 8'he2);
        step(7'h20, pc_in);
        check(core_control_q, 8'he0);
        reg_write(4'h3, 8'he2);
        reg_read(4'h3);
        check(rd, 8'he2);
        $display("Test control and gating done");
        reg_write(4'h4, 8'hff);
        reg_read(4'h4);
        check(rd, 8'h1f);
        reg_write(4'h4, 8'h00);
        ovf = 8'h00;
        for (int n = 0; n < 16; n++) begin
            lf = lfsr(lf);
            r = (n % 4 == 0) ? 8'h00 : lf[7:0];
            @(posedge clock);
            {alu_result, alu_upd_ovf, alu_carry_out, alu_carry_in7} <= {r, lf[10:8]};
            step(7'h40, pc_in);
            if (lf[10]) ovf[0] = lf[9] ^ lf[8];
            reg_read(4'h4);
            check(rd, {4'h0, r[7] ^ (lf[10] & ovf[0]), r == 8'h00, ovf[0], lf[9]});
        end
        @(posedge clock);
        req <= 4'h8;
        reg_write(4'h4, 8'h00);
        req <= 4'h0;
        reg_read(4'h4);
        check(rd[4], 1'b1);
        $display("Test flags done");
        finish_test();
    end
endmodule : testbench
